// ### logic/pwr_guard_pkg.sv
// Constants for the power-state and write-guard block
package pwr_guard_pkg;
  localparam int unsigned CLK_PERIOD_NS      = 5;
  // Standby return delay after a plain stop, ns
  localparam int unsigned STOP_IDLE_NS       = 200;
  localparam int unsigned STOP_IDLE_CYC      = (STOP_IDLE_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                               (STOP_IDLE_NS / CLK_PERIOD_NS);
  // Write cycle time, ms, and its length in clocks
  localparam int unsigned WRITE_CYCLE_MS     = 10;
  localparam int unsigned WRITE_CYCLE_CYC    = WRITE_CYCLE_MS * 1000000 / CLK_PERIOD_NS;
  // Power-on hold times, ms, one per delay select code
  localparam int unsigned HOLD_50_MS         = 50;
  localparam int unsigned HOLD_200_MS        = 200;
  localparam int unsigned HOLD_400_MS        = 400;
  localparam int unsigned HOLD_800_MS        = 800;
  localparam int unsigned HOLD_50_CYC        = HOLD_50_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned HOLD_200_CYC       = HOLD_200_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned HOLD_400_CYC       = HOLD_400_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned HOLD_800_CYC       = HOLD_800_MS * 1000000 / CLK_PERIOD_NS;
  // Serial clocks after start before a bad type byte returns to standby
  localparam logic [3:0]  MISMATCH_SCL_CNT   = 4'h9;
  // Clocks in one data byte plus acknowledge
  localparam logic [3:0]  BYTE_ACK_CLKS      = 4'h9;
  // Steps of the control-register unlock sequence
  localparam logic [1:0]  UNLOCK_STEPS       = 2'h3;
  // Delay select reset value (200 ms code)
  localparam logic [1:0]  HOLD_SEL_RST       = 2'h1;
  localparam logic        WR_LATCH_RST       = 1'b0;

  typedef enum logic [3:0] {
    ST_STANDBY = 4'h1,
    ST_ACTIVE  = 4'h2,
    ST_STOPWT  = 4'h4,
    ST_WRITING = 4'h8
  } pwr_state_t;
endpackage

// ### logic/pwr_guard.sv
// Power-state tracking and inadvertent-write guard
module pwr_guard
  import pwr_guard_pkg::*;
#(
  parameter int unsigned HOLD_50_P  = HOLD_50_CYC,      // 50 ms hold in clocks
  parameter int unsigned HOLD_200_P = HOLD_200_CYC,     // 200 ms hold in clocks
  parameter int unsigned HOLD_400_P = HOLD_400_CYC,     // 400 ms hold in clocks
  parameter int unsigned HOLD_800_P = HOLD_800_CYC,     // 800 ms hold in clocks
  parameter int unsigned WRITE_P    = WRITE_CYCLE_CYC   // write cycle in clocks
) (
  input  wire logic sys_clk_i,                 // 200 MHz clock
  input  wire logic rst_n_i,                   // Power-on reset, active low
  input  wire logic start_det_i,               // Pulse: start condition seen
  input  wire logic stop_det_i,                // Pulse: stop condition seen
  input  wire logic scl_rise_i,                // Pulse: serial clock rising edge
  input  wire logic type_match_i,              // Pulse: address type bits matched
  input  wire logic type_miss_i,               // Pulse: address type bits wrong
  input  wire logic wr_op_i,                   // Level: current transfer is a write
  input  wire logic data_byte_i,               // Pulse: data byte plus ack done
  input  wire logic wr_latch_set_i,            // Pulse: set write-enable latch
  input  wire logic wr_latch_clr_i,            // Pulse: clear write-enable latch
  input  wire logic unlock_step_i,             // Pulse: valid unlock step seen
  input  wire logic unlock_abort_i,            // Pulse: wrong unlock step
  input  wire logic ctrl_wr_req_i,             // Pulse: control register write request
  input  wire logic power_on_delay_sel_hi_i,   // Hold select high bit
  input  wire logic power_on_delay_sel_lo_i,   // Hold select low bit
  output logic      sda_o,                     // Data line output value
  output logic      sda_oe_o,                  // Data line drive enable
  output logic      active_o,                  // Device is active
  output logic      busy_o,                    // Nonvolatile write in progress
  output logic      nack_addr_o,               // Withhold address acknowledge
  output logic      write_launch_o,            // Pulse: nonvolatile write begins
  output logic      ctrl_wr_ok_o,              // Pulse: control write accepted
  output logic      write_enable_latch_o,      // Write-enable latch state
  output logic      sup_reset_o                // Supervisor reset, active high
);

  pwr_state_t  state_ff;
  pwr_state_t  nxt_state;
  logic [31:0] hold_cnt_ff;
  logic [31:0] tmr_ff;
  logic [3:0]  scl_cnt_ff;
  logic        miss_ff;
  logic        byte_ok_ff;
  logic        addr_ok_ff;
  logic        wr_latch_ff;
  logic [1:0]  unlock_ff;
  logic        hold_done_ff;
  logic [1:0]  hold_sel;
  logic        launch;

  // Hold length for the two-bit select code
  function automatic logic [31:0] hold_len(input logic [1:0] sel);
    case (sel)
      2'h0:    hold_len = 32'(HOLD_50_P);
      2'h1:    hold_len = 32'(HOLD_200_P);
      2'h2:    hold_len = 32'(HOLD_400_P);
      default: hold_len = 32'(HOLD_800_P);
    endcase
  endfunction

  // Power-on hold counter; zeroed by every reset so the hold is uninterrupted.
  // Done flag is sticky: a later select change must not re-assert reset.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_cnt_ff  <= 32'h0;
      hold_done_ff <= 1'b0;
    end else if (!hold_done_ff) begin
      hold_cnt_ff <= hold_cnt_ff + 32'h1;
      if (hold_cnt_ff >= hold_len(hold_sel) - 32'h1) begin
        hold_done_ff <= 1'b1;
      end
    end
  end
  assign hold_sel    = {power_on_delay_sel_hi_i, power_on_delay_sel_lo_i};
  assign sup_reset_o = !hold_done_ff;

  // Write-enable latch; clear at power-up, set request wins over clear
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_latch_ff <= WR_LATCH_RST;
    end else if (wr_latch_set_i) begin
      wr_latch_ff <= 1'b1;
    end else if (wr_latch_clr_i) begin
      wr_latch_ff <= 1'b0;
    end
  end
  assign write_enable_latch_o = wr_latch_ff;

  // Unlock sequence progress; any abort or control write request, accepted or not, starts over
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      unlock_ff <= 2'h0;
    end else if (unlock_abort_i || ctrl_wr_req_i) begin
      unlock_ff <= 2'h0;
    end else if (unlock_step_i && unlock_ff != UNLOCK_STEPS) begin
      unlock_ff <= unlock_ff + 2'h1;
    end
  end
  assign ctrl_wr_ok_o = ctrl_wr_req_i && (unlock_ff == UNLOCK_STEPS) && wr_latch_ff;

  // Serial clocks since start and data-byte completion tracking
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_cnt_ff <= 4'h0;
      miss_ff    <= 1'b0;
      byte_ok_ff <= 1'b0;
      addr_ok_ff <= 1'b0;
    end else if (start_det_i) begin
      scl_cnt_ff <= 4'h0;
      miss_ff    <= 1'b0;
      byte_ok_ff <= 1'b0;
      addr_ok_ff <= 1'b0;
    end else begin
      if (scl_rise_i && scl_cnt_ff != MISMATCH_SCL_CNT) begin
        scl_cnt_ff <= scl_cnt_ff + 4'h1;
      end
      // A write is only ours once the type bits have matched
      if (type_match_i) begin
        addr_ok_ff <= 1'b1;
      end
      if (type_miss_i) begin
        miss_ff <= 1'b1;
      end
      // Only whole byte plus ack counts; a partial byte stays refused
      if (data_byte_i) begin
        byte_ok_ff <= 1'b1;
      end
    end
  end

  // Launch needs latch set, write transfer and a full data byte
  assign launch         = (state_ff == ST_ACTIVE) && stop_det_i && wr_op_i && wr_latch_ff && addr_ok_ff &&
                          byte_ok_ff;
  assign write_launch_o = launch;

  // Power state sequencing
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_STANDBY: begin
        if (start_det_i) nxt_state = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        if (launch) nxt_state = ST_WRITING;
        else if (stop_det_i) nxt_state = ST_STOPWT;
        else if (miss_ff && scl_cnt_ff == MISMATCH_SCL_CNT) nxt_state = ST_STANDBY;
      end
      ST_STOPWT: begin
        if (start_det_i) nxt_state = ST_ACTIVE;
        else if (tmr_ff == 32'(STOP_IDLE_CYC - 1)) nxt_state = ST_STANDBY;
      end
      ST_WRITING: begin
        if (tmr_ff == 32'(WRITE_P - 1)) nxt_state = ST_STANDBY;
      end
      default: nxt_state = ST_STANDBY;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_STANDBY;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Delay timer restarts on every state change
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tmr_ff <= 32'h0;
    end else if (nxt_state != state_ff) begin
      tmr_ff <= 32'h0;
    end else begin
      tmr_ff <= tmr_ff + 32'h1;
    end
  end

  assign active_o    = state_ff != ST_STANDBY;
  assign busy_o      = state_ff == ST_WRITING;
  // Polling master sees no acknowledge until the cycle ends
  assign nack_addr_o = busy_o;
  // Data line never driven by this block; it only releases it
  assign sda_o       = 1'b0;
  assign sda_oe_o    = 1'b0;

  // Plain stop: a stop while active that launches no write
  sequence stop_plain_s;
    state_ff == ST_ACTIVE && stop_det_i && !launch;
  endsequence
  // No start for 39 or 40 clocks; the standby delay is 40 clocks of 5 ns
  sequence quiet39_s;
    (!start_det_i) throughout (##38 1'b1);
  endsequence
  sequence quiet40_s;
    (!start_det_i) throughout (##39 1'b1);
  endsequence

  chk_hold_reset_out: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $fell(sup_reset_o) |-> hold_cnt_ff >= hold_len(hold_sel)) else $error("reset released before hold done");
  chk_hold_sticky: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !sup_reset_o |=> !sup_reset_o) else $error("reset asserted again after release");
  chk_latch_blocks_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    write_launch_o |-> wr_latch_ff) else $error("write launched with latch clear");
  chk_partial_byte: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (stop_det_i && !byte_ok_ff) |-> !write_launch_o) else $error("write after partial byte");
  chk_unlock_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ctrl_wr_ok_o |-> unlock_ff == UNLOCK_STEPS) else $error("control write without unlock");
  chk_start_active: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_ff == ST_STANDBY && start_det_i) |=> active_o) else $error("start did not wake");
  chk_stop_standby: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    stop_plain_s ##1 quiet40_s |=> !active_o) else $error("no standby after stop");
  chk_stop_linger: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    stop_plain_s ##1 quiet39_s |=> active_o) else $error("standby too soon after stop");
  chk_miss_standby: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_ff == ST_ACTIVE && miss_ff && scl_cnt_ff == MISMATCH_SCL_CNT && !stop_det_i) |=> !active_o)
    else $error("no standby after type mismatch");
  chk_write_busy: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    write_launch_o |=> busy_o && nack_addr_o) else $error("write not busy");
  chk_sda_release: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !sda_oe_o) else $error("data line driven");
endmodule

// ### tb/bus_front_model.sv
// Bus front-end model: decodes the bench's event code into one-cycle pulses
module bus_front_model (
  input  wire logic [3:0] ev_code_i,       // Event chosen by the bench
  input  wire logic       ev_vld_i,        // Event strobe, one clock wide
  output logic            start_o,         // Start condition seen
  output logic            stop_o,          // Stop condition seen
  output logic            scl_rise_o,      // Serial clock rising edge
  output logic            match_o,         // Address type bits matched
  output logic            miss_o,          // Address type bits wrong
  output logic            byte_o,          // Data byte plus ack done
  output logic            latch_set_o,     // Set write-enable latch
  output logic            latch_clr_o,     // Clear write-enable latch
  output logic            step_o,          // Valid unlock step
  output logic            abort_o,         // Wrong unlock step
  output logic            ctrl_req_o       // Control register write request
);
  timeunit 1ns;
  timeprecision 1ps;
  // One pulse per strobe; only one event can stand in any clock
  assign start_o     = ev_vld_i && ev_code_i == 4'h0;
  assign stop_o      = ev_vld_i && ev_code_i == 4'h1;
  assign scl_rise_o  = ev_vld_i && ev_code_i == 4'h2;
  assign match_o     = ev_vld_i && ev_code_i == 4'h3;
  assign miss_o      = ev_vld_i && ev_code_i == 4'h4;
  assign byte_o      = ev_vld_i && ev_code_i == 4'h5;
  assign latch_set_o = ev_vld_i && ev_code_i == 4'h6;
  assign latch_clr_o = ev_vld_i && ev_code_i == 4'h7;
  assign step_o      = ev_vld_i && ev_code_i == 4'h8;
  assign abort_o     = ev_vld_i && ev_code_i == 4'h9;
  assign ctrl_req_o  = ev_vld_i && ev_code_i == 4'ha;
endmodule

// ### tb/pwr_guard_test.sv
// Self-checking bench for the power-state and write guard
module pwr_guard_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WR = 100;
  logic        sys_clk, rst_n, wr_op, sel_hi, sel_lo, ev_vld;
  logic [3:0]  ev_code;
  logic        start, stop, scl_rise, match, miss, byte_done, latch_set, latch_clr, step, abort, ctrl_req;
  logic        sda, sda_oe, active, busy, nack, launch, ctrl_ok, wr_latch, sup_rst;
  int          failures, num_checks, cyc, launches, oks;
  int          hold [4] = '{50, 200, 400, 800};

  bus_front_model i_master (
    .ev_code_i(ev_code), .ev_vld_i(ev_vld), .start_o(start), .stop_o(stop), .scl_rise_o(scl_rise),
    .match_o(match), .miss_o(miss), .byte_o(byte_done), .latch_set_o(latch_set), .latch_clr_o(latch_clr),
    .step_o(step), .abort_o(abort), .ctrl_req_o(ctrl_req));
  // Short hold and write counts keep the run brief
  pwr_guard #(.HOLD_50_P(50), .HOLD_200_P(200), .HOLD_400_P(400), .HOLD_800_P(800), .WRITE_P(WR)) i_dut (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .start_det_i(start), .stop_det_i(stop), .scl_rise_i(scl_rise),
    .type_match_i(match), .type_miss_i(miss), .wr_op_i(wr_op), .data_byte_i(byte_done),
    .wr_latch_set_i(latch_set), .wr_latch_clr_i(latch_clr), .unlock_step_i(step), .unlock_abort_i(abort),
    .ctrl_wr_req_i(ctrl_req), .power_on_delay_sel_hi_i(sel_hi), .power_on_delay_sel_lo_i(sel_lo),
    .sda_o(sda), .sda_oe_o(sda_oe), .active_o(active), .busy_o(busy), .nack_addr_o(nack),
    .write_launch_o(launch), .ctrl_wr_ok_o(ctrl_ok), .write_enable_latch_o(wr_latch), .sup_reset_o(sup_rst));

  initial sys_clk = 1'b0;
  always #2.5 sys_clk = ~sys_clk;
  // Pulse outputs last one cycle, so count them mid-cycle
  always @(negedge sys_clk) begin
    launches += int'(launch === 1'b1);
    oks += int'(ctrl_ok === 1'b1);
  end
  // Hang guard, several times the expected run
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic chk(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  // Wait n edges, then settle to the falling edge
  task automatic at(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic do_reset(input logic hi, input logic lo);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    sel_hi <= hi;
    sel_lo <= lo;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    at(0);
  endtask
  task automatic report_and_stop();
    if (failures == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // One event, raised after an edge and held for one clock
  task automatic send(input logic [3:0] code);
    @(posedge sys_clk);
    ev_code <= code;
    ev_vld  <= 1'b1;
    @(posedge sys_clk);
    ev_vld  <= 1'b0;
  endtask
  // Start, matched address, optional data byte, stop
  task automatic frame(input logic with_byte);
    send(4'h0);
    send(4'h3);
    if (with_byte) begin
      send(4'h5);
    end
    send(4'h1);
  endtask
  // Unlock steps; a short count is how refusals are provoked
  task automatic unlock(input int n);
    repeat (n) send(4'h8);
  endtask

  initial begin
    {rst_n, wr_op, sel_hi, sel_lo} = 4'h1;
    ev_vld  = 1'b0;
    ev_code = 4'h0;
    for (int s = 0; s < 4; s++) begin
      do_reset(s[1], s[0]);
      chk(active, 1'b0, "not standby");
      chk(wr_latch, 1'b0, "latch set at reset");
      chk(sda_oe, 1'b0, "data line driven");
      chk(sda, 1'b0, "data line value not low");
      at(hold[s] - 5);
      chk(sup_rst, 1'b1, "reset released early");
      at(10);
      chk(sup_rst, 1'b0, "reset held too long");
    end
    // Second reset in mid-hold restarts the count
    do_reset(1'b0, 1'b1);
    at(150);
    do_reset(1'b0, 1'b1);
    at(150);
    chk(sup_rst, 1'b1, "hold not restarted");
    send(4'h1);
    send(4'h5);
    at(0);
    chk(active, 1'b0, "woke without start");
    @(posedge sys_clk) wr_op <= 1'b1;
    frame(1'b1);
    at(0);
    chk(launches == 0, 1'b1, "write with latch clear");
    at(30);
    chk(active, 1'b1, "standby too soon");
    at(15);
    chk(active, 1'b0, "no standby after stop");
    // Latch set but stop before any data byte
    send(4'h6);
    frame(1'b0);
    at(0);
    chk(wr_latch, 1'b1, "latch not set");
    chk(launches == 0, 1'b1, "write without data byte");
    at(45);
    chk(active, 1'b0, "no standby after short write");
    // Data byte but no address match: refused
    send(4'h0);
    send(4'h5);
    send(4'h1);
    at(0);
    chk(launches == 0, 1'b1, "write without address match");
    at(45);
    // Full frame on a read transfer: refused
    @(posedge sys_clk) wr_op <= 1'b0;
    frame(1'b1);
    at(0);
    chk(launches == 0, 1'b1, "read transfer launched a write");
    chk(busy, 1'b0, "busy after read stop");
    at(45);
    @(posedge sys_clk) wr_op <= 1'b1;
    frame(1'b1);
    at(1);
    chk(launches == 1, 1'b1, "valid write not launched");
    chk(busy, 1'b1, "not busy");
    chk(nack, 1'b1, "address acked while busy");
    send(4'h0);
    at(WR - 20);
    chk(busy, 1'b1, "write cut short");
    chk(active, 1'b1, "inactive during write");
    at(30);
    chk(busy, 1'b0, "write overran");
    chk(active, 1'b0, "active after write");
    chk(nack, 1'b0, "nack after write");
    send(4'h7);
    at(0);
    chk(wr_latch, 1'b0, "latch not cleared");
    // Bad type byte: standby on the ninth serial clock
    send(4'h0);
    at(0);
    chk(busy, 1'b0, "busy without a write");
    chk(active, 1'b1, "start not seen");
    repeat (8) send(4'h2);
    send(4'h4);
    at(0);
    chk(active, 1'b1, "standby before nine clocks");
    send(4'h2);
    at(1);
    chk(active, 1'b0, "no standby on mismatch");
    // Unlock: short count, abort, then full sequence
    send(4'h6);
    unlock(2);
    send(4'ha);
    unlock(2);
    send(4'h9);
    unlock(1);
    send(4'ha);
    at(0);
    chk(oks == 0, 1'b1, "control write without unlock");
    unlock(3);
    send(4'ha);
    at(0);
    chk(oks == 1, 1'b1, "unlocked control write refused");
    report_and_stop();
  end
endmodule
